// *** rtl/imd_datapath.sv ***
// Sample FIFO and the interpolate, modulate and zero-stuff datapath top
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module imd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } imd_fifo_state_t;

  imd_fifo_state_t st;
  imd_fifo_state_t next_st;
  logic push;
  logic pop;

  assign push = in_valid_i && !st.full;
  assign pop = out_ready_i && !st.empty;
  assign in_ready_o = !st.full;
  assign out_valid_o = !st.empty;
  assign out_data_o = st.mem[st.rp];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: next_st.cnt = st.cnt + 1'b1;
      2'b01: next_st.cnt = st.cnt - 1'b1;
      default: next_st.cnt = st.cnt;
    endcase
    // Flags kept in flops so the fill-side ready is registered
    next_st.full = (next_st.cnt == (AW + 1)'(DEPTH));
    next_st.empty = (next_st.cnt == '0);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.empty <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  full_blocks_a: assert property (@(posedge clk_i) disable iff (reset_i)
    st.full |-> !in_ready_o && (st.cnt == (AW + 1)'(DEPTH)))
    else $error("fifo full but still ready");
endmodule : imd_fifo

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - I and Q each own three half-band stages
// - Interpolation rate from mode bits 7:6
// - Rate code 00 bypasses all filtering
// - Code 01 doubles; half-rate carrier +1,-1
// - Code 10 quadruples; quarter carrier 0,+1,0,-1
// - Code 11 octuples; eighth carrier of 0.707 steps
// - Modulation frequency from mode bits 5:4
// - Modulator acts on filter outputs, or on the raw input at rate code 00
// - Stuffing bit doubles rate, inserts midscale
// - Midscale inserted after modulator, before converter
// - Bit 2 couples both modulators into complex
// - Complex rotation selectable positive or negative
// - Positive rotation: cosine real, sine imaginary
// - Bit 1 selects the rotation direction
// - Complex result valid only at quarter, eighth
// - Sample clock is converter clock over ratio
module imd_datapath (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Mode register port
  input wire logic reg_wr_i,
  input wire logic [imd_pkg::REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [imd_pkg::REG_DATA_W-1:0] reg_wdata_i,
  output logic [imd_pkg::REG_DATA_W-1:0] reg_rdata_o,
  // Baseband sample source
  input wire logic src_valid_i,
  input wire imd_pkg::imd_iq_t src_data_i,
  output logic src_ready_o,
  output logic input_sample_clock_out_o,
  output logic underrun_o,
  // Converter core codes, offset binary
  output logic [imd_pkg::SAMPLE_W-1:0] dac_i_o,
  output logic [imd_pkg::SAMPLE_W-1:0] dac_q_o
);
  import imd_pkg::*;

  typedef struct packed {
    imd_mode_t mode;
    logic [3:0] dc;
    logic [2:0] mph;
    logic [1:0][NUM_STAGES-1:0][HB_TAPS-1:0][SAMPLE_W-1:0] dly;
    logic [1:0][NUM_STAGES-1:0][SAMPLE_W-1:0] sout;
    logic [1:0][SAMPLE_W-1:0] fsmp;
    logic [1:0][SAMPLE_W-1:0] modo;
    logic [1:0][SAMPLE_W-1:0] dac;
    logic clk_out;
    logic [REG_DATA_W-1:0] rdata;
    logic underrun;
  } imd_state_t;

  imd_state_t st;
  imd_state_t next_st;
  logic tick;
  logic take;
  logic [2:0] p;
  logic [2:0] shamt;
  logic [4:0] period;
  logic fifo_valid;
  imd_iq_t fifo_data;

  function automatic logic [15:0] sat16(input logic signed [21:0] v);
    if (v > 22'sh007FFF) begin
      return 16'h7FFF;
    end else if (v < 22'sh3F8000) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction : sat16

  // Odd phase tap set -1, 9, 9, -1 over 16; unity gain so no rescale needed
  function automatic logic [15:0] halfband(input logic [HB_TAPS-1:0][SAMPLE_W-1:0] d);
    logic signed [21:0] a;
    logic signed [21:0] b;
    logic signed [21:0] acc;
    a = 22'($signed(d[1])) + 22'($signed(d[2]));
    b = 22'($signed(d[0])) + 22'($signed(d[3]));
    acc = 22'(a * HB_INNER) - b;
    return sat16(acc >>> HB_SHIFT);
  endfunction : halfband

  // Eighth-rate sine table; code 2 is unity, code 1 is 0.707
  function automatic logic signed [2:0] sine8(input logic [2:0] m);
    case (m)
      3'h1, 3'h3: return 3'sh1;
      3'h2: return 3'sh2;
      3'h5, 3'h7: return -3'sh1;
      3'h6: return -3'sh2;
      default: return 3'sh0;
    endcase
  endfunction : sine8

  function automatic logic signed [21:0] cmul(input logic [15:0] x,
                                             input logic signed [2:0] c);
    logic signed [21:0] xe;
    logic signed [21:0] h;
    xe = 22'($signed(x));
    h = 22'(xe * ROOT_HALF) >>> ROOT_SHIFT;
    case (c)
      3'sh2: return xe;
      -3'sh2: return -xe;
      3'sh1: return h;
      -3'sh1: return -h;
      default: return 22'sh000000;
    endcase
  endfunction : cmul

  ////////////////////////////////////////////////////////////////////////////
  // Rate timing, all derived from the mode register
  assign shamt = {1'b0, st.mode.interp} + {2'b00, st.mode.zstuff};
  assign period = 5'h01 << shamt;
  assign tick = st.mode.zstuff ? !st.dc[0] : 1'b1;
  assign p = st.mode.zstuff ? st.dc[3:1] : st.dc[2:0];
  assign take = tick && ((p & 3'((4'h1 << st.mode.interp) - 4'h1)) == 3'h0);

  imd_fifo #(
    .W($bits(imd_iq_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(src_valid_i),
    .in_data_i(src_data_i),
    .in_ready_o(src_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(take)
  );

  always_comb begin
    logic [1:0][SAMPLE_W-1:0] chain;
    logic [SAMPLE_W-1:0] src;
    logic [2:0] sidx;
    logic signed [2:0] sc;
    logic signed [2:0] cc;
    logic signed [2:0] sn;
    logic signed [2:0] car;
    chain = '0;
    src = '0;
    sidx = '0;
    sc = '0;
    cc = '0;
    sn = '0;
    car = '0;
    next_st = st;
    // Fresh baseband sample, or zero on underrun, on every input-rate slot
    if (take) begin
      if (fifo_valid) begin
        next_st.fsmp = {fifo_data.q, fifo_data.i};
      end else begin
        next_st.fsmp = '0;
        next_st.underrun = 1'b1;
      end
    end
    // Stage k sits k places from the output; inactive ones are skipped
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < NUM_STAGES; k++) begin
        if (k < int'(st.mode.interp)) begin
          src = (k + 1 < int'(st.mode.interp)) ? st.sout[ch][k+1] : st.fsmp[ch];
          if (tick && ((p & 3'((4'h1 << k) - 4'h1)) == 3'h0)) begin
            next_st.sout[ch][k] = p[k] ? halfband(st.dly[ch][k]) : st.dly[ch][k][1];
          end
          if (tick && ((p & 3'((4'h2 << k) - 4'h1)) == 3'h0)) begin
            next_st.dly[ch][k] = {st.dly[ch][k][2:0], src};
          end
        end
      end
      chain[ch] = (st.mode.interp == 2'h0) ? st.fsmp[ch] : st.sout[ch][0];
    end
    // Carrier phase steps once per modulated sample
    sidx = 3'(st.mph << (2'h3 - st.mode.modf));
    sc = sine8(sidx);
    cc = sine8(sidx + 3'h2);
    sn = st.mode.negrot ? -sc : sc;
    car = (st.mode.modf == IMD_MOD_HALF) ? cc : sc;
    if (tick) begin
      next_st.mph = st.mph + 3'h1;
      if (st.mode.modf == IMD_MOD_OFF) begin
        next_st.modo = chain;
      end else if (st.mode.cplx) begin
        // At half rate the sine is all zeros, so this degrades to real mixing
        next_st.modo[0] = sat16(cmul(chain[0], cc) - cmul(chain[1], sn));
        next_st.modo[1] = sat16(cmul(chain[0], sn) + cmul(chain[1], cc));
      end else begin
        next_st.modo[0] = sat16(cmul(chain[0], car));
        next_st.modo[1] = sat16(cmul(chain[1], car));
      end
    end
    // Stuffing slot follows every modulated sample
    for (int ch = 0; ch < 2; ch++) begin
      if (st.mode.zstuff && !tick) begin
        next_st.dac[ch] = MIDSCALE;
      end else begin
        next_st.dac[ch] = {~st.modo[ch][15], st.modo[ch][14:0]};
      end
    end
    next_st.dc = ({1'b0, st.dc} == period - 5'h01) ? 4'h0 : st.dc + 4'h1;
    // A mode write restarts divider and carrier phase
    if (reg_wr_i && (reg_addr_i == MODE_REG_ADDR)) begin
      next_st.mode = imd_mode_t'(reg_wdata_i);
      next_st.dc = 4'h0;
      next_st.mph = 3'h0;
      next_st.underrun = take && !fifo_valid;
    end
    // Undivided case cannot toggle from a flop, so it stays high
    next_st.clk_out = (period == 5'h01) || ({1'b0, next_st.dc} < (period >> 1));
    next_st.rdata = (reg_addr_i == MODE_REG_ADDR) ? st.mode : 8'h00;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.mode <= imd_mode_t'(MODE_REG_RESET);
      st.dac <= {MIDSCALE, MIDSCALE};
      st.clk_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign input_sample_clock_out_o = st.clk_out;
  assign underrun_o = st.underrun;
  assign dac_i_o = st.dac[0];
  assign dac_q_o = st.dac[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  logic [4:0] since_take;
  logic armed;
  logic [1:0][SAMPLE_W-1:0] chain_now;

  assign chain_now[0] = (st.mode.interp == 2'h0) ? st.fsmp[0] : st.sout[0][0];
  assign chain_now[1] = (st.mode.interp == 2'h0) ? st.fsmp[1] : st.sout[1][0];

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      since_take <= 5'h00;
      armed <= 1'b0;
    end else if (reg_wr_i) begin
      since_take <= 5'h00;
      armed <= 1'b0;
    end else if (take) begin
      since_take <= 5'h00;
      armed <= 1'b1;
    end else begin
      since_take <= since_take + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence stuff_slot_s;
    st.mode.zstuff && !tick;
  endsequence

  sequence quarter_real_s;
    tick && st.mode.modf == IMD_MOD_QUARTER && !st.mode.cplx;
  endsequence

  property midscale_p;
    stuff_slot_s |=> (dac_i_o == MIDSCALE) && (dac_q_o == MIDSCALE);
  endproperty

  property quarter_zero_p;
    quarter_real_s ##0 !st.mph[0] |=> st.modo[0] == 16'h0000 && st.modo[1] == 16'h0000;
  endproperty

  take_spacing_a: assert property (take && armed |-> since_take == period - 5'h01)
    else $error("input slot spacing wrong");
  bypass_rate_a: assert property (st.mode.interp == 2'h0 && !st.mode.zstuff |-> take)
    else $error("bypass mode missed a slot");
  clock_edge_a: assert property (take |-> input_sample_clock_out_o)
    else $error("sample clock low at take");
  stuff_midscale_a: assert property (midscale_p)
    else $error("stuff slot not midscale");
  quarter_zero_a: assert property (quarter_zero_p)
    else $error("quarter carrier zero step");
  pass_through_a: assert property (tick && st.mode.modf == IMD_MOD_OFF
    |=> st.modo == $past(chain_now))
    else $error("unmodulated sample altered");
  half_negate_a: assert property (tick && st.mode.modf == IMD_MOD_HALF && !st.mode.cplx
    && st.mph[0] && chain_now[0] != 16'h8000
    |=> st.modo[0] == 16'(~$past(chain_now[0]) + 16'h0001))
    else $error("half rate sign step wrong");
  cplx_cos_a: assert property (tick && st.mode.cplx && st.mode.modf == IMD_MOD_QUARTER
    && st.mph[1:0] == 2'h0 |=> st.modo == $past(chain_now))
    else $error("complex cosine step wrong");
  cplx_neg_a: assert property (tick && st.mode.cplx && st.mode.negrot
    && st.mode.modf == IMD_MOD_QUARTER && st.mph[1:0] == 2'h1
    |=> st.modo[0] == $past(chain_now[1]))
    else $error("negative rotation wrong");
endmodule : imd_datapath

`default_nettype wire

// *** rtl/imd_pkg.sv ***
// Constants, field layouts and carrier types for the interpolating modulator datapath
package imd_pkg;
  localparam int SAMPLE_W = 16;
  localparam int NUM_STAGES = 3;
  localparam int HB_TAPS = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int REG_ADDR_W = 5;
  localparam int REG_DATA_W = 8;

  // Register map
  localparam logic [4:0] MODE_REG_ADDR = 5'h01;
  localparam logic [7:0] MODE_REG_RESET = 8'h00;

  // Field positions inside the mode register
  localparam int INTERP_HI = 7;
  localparam int INTERP_LO = 6;
  localparam int MODF_HI = 5;
  localparam int MODF_LO = 4;
  localparam int ZSTUFF_BIT = 3;
  localparam int CPLX_BIT = 2;
  localparam int NEGROT_BIT = 1;

  // Datapath constants
  localparam logic [15:0] MIDSCALE = 16'h8000;
  localparam logic signed [7:0] HB_INNER = 8'sh09;
  localparam int HB_SHIFT = 4;
  localparam logic signed [9:0] ROOT_HALF = 10'sh0B5;
  localparam int ROOT_SHIFT = 8;

  typedef enum logic [1:0] {
    IMD_MOD_OFF,
    IMD_MOD_HALF,
    IMD_MOD_QUARTER,
    IMD_MOD_EIGHTH
  } imd_modf_t;

  // Same bit order as the mode register
  typedef struct packed {
    logic [1:0] interp;
    imd_modf_t modf;
    logic zstuff;
    logic cplx;
    logic negrot;
    logic spare;
  } imd_mode_t;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } imd_iq_t;
endpackage : imd_pkg

// *** sim/imd_src_model.sv ***
// Baseband source model: constant I/Q words over a valid/ready handshake
`timescale 1ns/1ps
`default_nettype none

module imd_src_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control from the bench
  input wire logic en_i,
  input wire logic signed [15:0] i_val_i,
  input wire logic signed [15:0] q_val_i,
  // Handshake toward the block
  input wire logic ready_i,
  output logic valid_o,
  output imd_pkg::imd_iq_t data_o
);
  import imd_pkg::*;
  // Word is only replaced once the held one was taken
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      valid_o <= 1'b0;
      data_o <= '0;
    end else if (!valid_o || ready_i) begin
      valid_o <= en_i;
      data_o <= '{i: i_val_i, q: q_val_i};
    end
  end
endmodule : imd_src_model

`default_nettype wire

// *** sim/interp_modulator_datapath_test.sv ***
// Self-checking bench for the interpolating modulator datapath
`timescale 1ns/1ps
`default_nettype none

module interp_modulator_datapath_test;
  import imd_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic src_en = 1'b0;
  logic signed [15:0] i_val = 16'sh0100;
  logic signed [15:0] q_val = -16'sh0100;
  logic src_valid, src_ready, sclk, underrun;
  imd_iq_t src_data;
  logic [7:0] rdata;
  logic [15:0] dac_i, dac_q;
  logic [15:0] si [16];
  logic [15:0] sq [16];
  int err_total = 0;
  int n_compared = 0;

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  imd_src_model src (.clk_i(clk_i), .reset_i(reset_i), .en_i(src_en), .i_val_i(i_val),
    .q_val_i(q_val), .ready_i(src_ready), .valid_o(src_valid), .data_o(src_data));

  imd_datapath uut (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .src_valid_i(src_valid), .src_data_i(src_data), .src_ready_o(src_ready),
    .input_sample_clock_out_o(sclk), .underrun_o(underrun), .dac_i_o(dac_i),
    .dac_q_o(dac_q));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_addr <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  // Samples converted from offset binary to two's complement
  task automatic grab();
    for (int n = 0; n < 16; n++) begin
      @(negedge clk_i);
      si[n] = dac_i ^ MIDSCALE;
      sq[n] = dac_q ^ MIDSCALE;
    end
  endtask : grab

  // Eighth-rate sine carrier scaled to a DC level of 256
  function automatic logic [15:0] s8(input int x);
    case (x % 8)
      0, 4: return 16'h0000;
      1, 3: return 16'h00B5;
      2: return 16'h0100;
      5, 7: return 16'hFF4B;
      default: return 16'hFF00;
    endcase
  endfunction : s8

  function automatic int peak(input logic [15:0] s [16]);
    for (int k = 0; k < 8; k++) if (s[k] === 16'h0100) return k;
    return -1;
  endfunction : peak

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(5'h01, 8'h00);
    wr(5'h01, 8'hA5);
    wr(5'h02, 8'h3C);
    rd(5'h01, 8'hA5);
    rd(5'h02, 8'h00);
    $display("regs done");
  endtask : t_regs

  // DC passes every rate unchanged with modulation off
  task automatic t_pass();
    for (int r = 0; r < 4; r++) begin
      wr(5'h01, 8'(r << 6));
      cyc(200);
      grab();
      chk(si[0], 16'h0100);
      chk(si[15], 16'h0100);
      chk(sq[7], 16'hFF00);
    end
    $display("pass-through done");
  endtask : t_pass

  task automatic t_real(input logic [7:0] mode, input int n);
    int k;
    wr(5'h01, mode);
    cyc(200);
    grab();
    k = peak(si);
    if (k < 0) begin
      chk(si[0], 16'h0100);
    end else begin
      for (int j = 0; j < 8; j++) begin
        chk(si[k + j], s8(2 + j * (8 / n)));
        chk(sq[k + j], -s8(2 + j * (8 / n)));
      end
    end
    $display("real mode %h done", mode);
  endtask : t_real

  task automatic t_stuff();
    int k;
    wr(5'h01, 8'h48);
    cyc(200);
    grab();
    k = peak(si);
    if (k < 0) k = 0;
    for (int j = 0; j < 8; j++) chk(si[k + j], (j % 2 == 0) ? 16'h0100 : 16'h0000);
    wr(5'h01, 8'h58);
    cyc(200);
    grab();
    // Half-rate carrier flips sign per data sample; midscale sits between them
    k = peak(si);
    if (k < 0) k = 0;
    chk(si[k + 1], 16'h0000);
    chk(si[k + 2], 16'hFF00);
    chk(si[k + 3], 16'h0000);
    $display("stuffing done");
  endtask : t_stuff

  // I alone drives both outputs once the modulators are coupled
  task automatic t_cplx(input logic [7:0] mode, input logic [15:0] exp);
    int k;
    q_val <= 16'sh0000;
    wr(5'h01, mode);
    cyc(200);
    grab();
    k = peak(sq);
    if (k < 0) k = 0;
    chk(sq[k], 16'h0100);
    chk(si[k], 16'h0000);
    chk(si[k + 1], exp);
    q_val <= -16'sh0100;
    $display("complex mode %h done", mode);
  endtask : t_cplx

  task automatic t_clk(input logic [7:0] mode, input int p);
    int ones;
    int falls;
    logic prev;
    wr(5'h01, mode);
    cyc(40);
    ones = 0;
    falls = 0;
    prev = 1'b1;
    // Window opens on a high phase, so falls count whole periods exactly
    for (int n = 0; n < 32; n++) begin
      @(negedge clk_i);
      if (sclk === 1'b1) ones++;
      if (sclk === 1'b0 && prev === 1'b1) falls++;
      prev = sclk;
    end
    chk(16'(ones), (p == 1) ? 16'd32 : 16'd16);
    chk(16'(falls), (p == 1) ? 16'd0 : 16'(32 / p));
    $display("clock mode %h done", mode);
  endtask : t_clk

  task automatic t_fifo();
    int n;
    wr(5'h01, 8'hC8);
    n = 0;
    while (src_ready !== 1'b0 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    chk({15'h0, src_ready}, 16'h0000);
    src_en <= 1'b0;
    cyc(300);
    @(negedge clk_i);
    chk({15'h0, src_ready}, 16'h0001);
    chk({15'h0, underrun}, 16'h0001);
    src_en <= 1'b1;
    cyc(10);
    wr(5'h01, 8'h40);
    cyc(4);
    @(negedge clk_i);
    chk({15'h0, underrun}, 16'h0000);
    $display("fifo done");
  endtask : t_fifo

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk(dac_i, MIDSCALE);
    chk({15'h0, src_ready}, 16'h0001);
    t_regs();
    src_en <= 1'b1;
    t_pass();
    t_real(8'h10, 2);
    t_real(8'h60, 4);
    t_real(8'h14, 2);
    t_real(8'hA0, 4);
    t_real(8'hF0, 8);
    t_real(8'h30, 8);
    t_stuff();
    t_cplx(8'h24, 16'hFF00);
    t_cplx(8'h26, 16'h0100);
    t_clk(8'h00, 1);
    t_clk(8'h40, 2);
    t_clk(8'h80, 4);
    t_clk(8'h88, 8);
    t_fifo();
    stop_test();
  end
endmodule : interp_modulator_datapath_test

`default_nettype wire
